// >>> src/dcg_pkg.sv
// dcg_pkg: register map, field layout and carriers of the camera general register group
package dcg_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // register offsets (16-bit word addresses)
   localparam logic [15:0] OFF_MODE    = 16'h0001;
   localparam logic [15:0] OFF_FLAGS   = 16'h0003;
   localparam logic [15:0] OFF_FORMAT  = 16'h0004;
   localparam logic [15:0] OFF_EXPO    = 16'h0005;
   localparam logic [15:0] OFF_HWID    = 16'h0006;
   localparam logic [15:0] OFF_BOARD   = 16'h0007;
   localparam logic [15:0] OFF_FREQ    = 16'h0009;
   localparam logic [15:0] OFF_UNLOCK  = 16'h0022;
   localparam logic [15:0] OFF_CMD     = 16'h0033;
   localparam logic [15:0] OFF_SWVER   = 16'h8000;
   localparam logic [15:0] OFF_FRATE   = 16'hA000;

   // reset values
   localparam logic [15:0] RST_MODE    = 16'h0001;
   localparam logic [15:0] RST_FLAGS   = 16'h0040;
   localparam logic [15:0] RST_FORMAT  = 16'h0000;
   localparam logic [15:0] RST_EXPO    = 16'h05DC;
   localparam logic [15:0] RST_FREQ    = 16'h07D0;
   localparam logic [15:0] RST_FRATE   = 16'h0028;
   localparam logic [15:0] RST_UNLOCK  = 16'h0000;

   // limits and keys
   localparam logic [15:0] EXPO_MIN    = 16'h0001;
   localparam logic [15:0] EXPO_MAX    = 16'h1D4C;
   localparam logic [15:0] KEY_FLASH   = 16'h4877;
   localparam logic [7:0]  FORMAT_MAX  = 8'h15;
   localparam logic [15:0] CMD_SAVE    = 16'h0001;
   localparam logic [15:0] CMD_CLEAR   = 16'h0002;

   // mode register fields
   localparam int unsigned MODE_VIDEO  = 0;
   localparam int unsigned MODE_TRIG   = 4;
   localparam int unsigned MODE_CLR    = 6;
   localparam int unsigned MODE_SNAP   = 11;

   // content select field
   localparam int unsigned FMT_LO      = 3;
   localparam int unsigned FMT_HI      = 10;

   // condition flag positions
   localparam int unsigned FL_LIGHT_T  = 3;
   localparam int unsigned FL_TIM_T    = 4;
   localparam int unsigned FL_CAL      = 5;
   localparam int unsigned FL_FACT     = 6;
   localparam int unsigned FL_RESTORE  = 8;
   localparam int unsigned FL_POE      = 10;
   localparam int unsigned FL_LIGHTERR = 11;
   localparam int unsigned FL_COLOUR   = 13;
   localparam int unsigned FL_BOARD_T  = 14;
   localparam int unsigned FL_TIM_ERR  = 15;

   // level conditions follow their source; event conditions are sticky
   localparam logic [15:0] LEVEL_MASK  = 16'hC038;
   localparam logic [15:0] STICKY_MASK = 16'h2D40;

   // register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } dcg_req_t;

   // condition inputs from the rest of the camera
   typedef struct packed {
      logic light_temp_err;
      logic tim_temp_err;
      logic calib_missing;
      logic factory_loaded;
      logic fw_restored;
      logic poe_limited;
      logic light_module_err;
      logic colour_err;
      logic board_temp_err;
      logic tim_fault;
   } dcg_cond_t;

   // one-cycle commands toward the camera
   typedef struct packed {
      logic manual_frame;
      logic snapshot;
      logic flash_save;
      logic flash_clear;
   } dcg_cmd_t;
endpackage

// >>> src/dcg_sync.sv
// dcg_sync: two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module dcg_sync #(
   parameter int unsigned W = 10
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// >>> src/dcg_flags.sv
// dcg_flags: condition flag word with level and sticky bits
`timescale 1ns/1ps
module dcg_flags (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // synchronised conditions
   input  dcg_pkg::dcg_cond_t cond,
   // clear request from the mode register
   input  wire logic        clear,
   // flag word
   output logic      [15:0] flags
);
   logic [15:0] raw;
   logic [15:0] sticky_r;
   logic [15:0] sticky_nxt;

   always_comb begin
      raw = '0;
      raw[dcg_pkg::FL_LIGHT_T]  = cond.light_temp_err;
      raw[dcg_pkg::FL_TIM_T]    = cond.tim_temp_err;
      raw[dcg_pkg::FL_CAL]      = cond.calib_missing;
      raw[dcg_pkg::FL_FACT]     = cond.factory_loaded;
      raw[dcg_pkg::FL_RESTORE]  = cond.fw_restored;
      raw[dcg_pkg::FL_POE]      = cond.poe_limited;
      raw[dcg_pkg::FL_LIGHTERR] = cond.light_module_err;
      raw[dcg_pkg::FL_COLOUR]   = cond.colour_err;
      raw[dcg_pkg::FL_BOARD_T]  = cond.board_temp_err;
      raw[dcg_pkg::FL_TIM_ERR]  = cond.tim_fault;
   end

   // a new event in the clear cycle survives the clear
   always_comb begin
      sticky_nxt = clear ? '0 : sticky_r;
      sticky_nxt = sticky_nxt | (raw & dcg_pkg::STICKY_MASK);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sticky_r <= dcg_pkg::RST_FLAGS;
      end else begin
         sticky_r <= sticky_nxt;
      end
   end

   assign flags = sticky_r | (raw & dcg_pkg::LEVEL_MASK);
endmodule

// >>> src/dcg_regs.sv
// dcg_regs: general control and status register group of the depth camera
// ****************************************************************
// What this block does
// - critical functions need prior unlock write
// - flash save/clear need flash unlock value
// - mode bit 0 selects manual/video, resets video
// - mode bit 4 triggers one frame, self-clears
// - mode bit 6 clears flags, self-clears
// - mode bit 11 triggers snapshot, self-clears
// - flag bit 3: light module temperature error
// - flag bit 4: timing module temperature error
// - flag bit 5: calibration data missing
// - flag bit 6: factory map loaded, reset value
// - flag bit 8: previous firmware restored
// - flag bit 10: power budget limited rates
// - flag bit 11: light module error reported
// - flag bit 13: colour stream failure
// - flag bit 14: base board temperature error
// - flag bit 15: timing module fault
// - format field bits 3-10, codes 0-21, reset 0
// - exposure microseconds, default 1500, range 1-7500
// - board info bits 0-3: PCB revision
// - version fields 0-5, 6-10, 11-15
// - modulation frequency in 10 kHz, default 2000
// ****************************************************************
`timescale 1ns/1ps
module dcg_regs #(
   parameter logic [15:0] HW_ID     = 16'h0A5A, // arbitrary value
   parameter logic [3:0]  BOARD_REV = 4'h0,     // arbitrary value
   parameter logic [5:0]  VER_FIX   = 6'h00,    // arbitrary value
   parameter logic [4:0]  VER_MINOR = 5'h00,    // arbitrary value
   parameter logic [4:0]  VER_MAJOR = 5'h01     // arbitrary value
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // register port
   input  dcg_pkg::dcg_req_t req,
   output logic       [15:0] rdata,
   // camera conditions, asynchronous levels
   input  dcg_pkg::dcg_cond_t cond_async,
   // settings toward the camera
   output logic              video_mode,
   output logic       [7:0]  content_select,
   output logic       [15:0] exposure_us,
   output logic       [15:0] mod_freq,
   output logic       [15:0] frame_rate,
   // one-cycle commands
   output dcg_pkg::dcg_cmd_t cmd
);
   // ****************************************************************
   // decode
   // ****************************************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   logic wr_mode;
   logic wr_format;
   logic wr_expo;
   logic wr_freq;
   logic wr_frate;
   logic wr_unlock;
   logic wr_cmd;

   assign wr_mode   = req.wr && hit(req.addr, dcg_pkg::OFF_MODE);
   assign wr_format = req.wr && hit(req.addr, dcg_pkg::OFF_FORMAT);
   assign wr_expo   = req.wr && hit(req.addr, dcg_pkg::OFF_EXPO);
   assign wr_freq   = req.wr && hit(req.addr, dcg_pkg::OFF_FREQ);
   assign wr_frate  = req.wr && hit(req.addr, dcg_pkg::OFF_FRATE);
   assign wr_unlock = req.wr && hit(req.addr, dcg_pkg::OFF_UNLOCK);
   assign wr_cmd    = req.wr && hit(req.addr, dcg_pkg::OFF_CMD);

   // ****************************************************************
   // conditions and flag word
   // ****************************************************************
   dcg_pkg::dcg_cond_t cond_s;
   logic [15:0]        flags;
   logic               clr_r;

   dcg_sync #(
      .W ($bits(dcg_pkg::dcg_cond_t))
   ) u_sync (
      .clock (clock),
      .reset (reset),
      .din   (cond_async),
      .dout  (cond_s)
   );

   dcg_flags u_flags (
      .clock (clock),
      .reset (reset),
      .cond  (cond_s),
      .clear (clr_r),
      .flags (flags)
   );

   // ****************************************************************
   // mode register
   // ****************************************************************
   logic video_r;
   logic trig_r;
   logic snap_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         video_r <= dcg_pkg::RST_MODE[dcg_pkg::MODE_VIDEO];
      end else if (wr_mode) begin
         video_r <= req.wdata[dcg_pkg::MODE_VIDEO];
      end
   end

   // self-clearing bits: high for exactly one cycle after the write
   always_ff @(posedge clock) begin
      if (reset) begin
         trig_r <= 1'b0;
         snap_r <= 1'b0;
         clr_r  <= 1'b0;
      end else begin
         trig_r <= wr_mode && req.wdata[dcg_pkg::MODE_TRIG];
         snap_r <= wr_mode && req.wdata[dcg_pkg::MODE_SNAP];
         clr_r  <= wr_mode && req.wdata[dcg_pkg::MODE_CLR];
      end
   end

   // ****************************************************************
   // settings
   // ****************************************************************
   logic [7:0]  format_r;
   logic [15:0] expo_r;
   logic [15:0] freq_r;
   logic [15:0] frate_r;
   logic [7:0]  fmt_in;
   logic [15:0] expo_nxt;

   assign fmt_in = req.wdata[dcg_pkg::FMT_HI:dcg_pkg::FMT_LO];

   // codes above the last defined one are ignored
   always_ff @(posedge clock) begin
      if (reset) begin
         format_r <= dcg_pkg::RST_FORMAT[dcg_pkg::FMT_HI:dcg_pkg::FMT_LO];
      end else if (wr_format && fmt_in <= dcg_pkg::FORMAT_MAX) begin
         format_r <= fmt_in;
      end
   end

   // out-of-range exposure is clamped into the legal range
   always_comb begin
      expo_nxt = req.wdata;
      if (req.wdata < dcg_pkg::EXPO_MIN) begin
         expo_nxt = dcg_pkg::EXPO_MIN;
      end else if (req.wdata > dcg_pkg::EXPO_MAX) begin
         expo_nxt = dcg_pkg::EXPO_MAX;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         expo_r <= dcg_pkg::RST_EXPO;
      end else if (wr_expo) begin
         expo_r <= expo_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         freq_r <= dcg_pkg::RST_FREQ;
      end else if (wr_freq) begin
         freq_r <= req.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         frate_r <= dcg_pkg::RST_FRATE;
      end else if (wr_frate) begin
         frate_r <= req.wdata;
      end
   end

   // ****************************************************************
   // unlock word and flash commands
   // ****************************************************************
   logic [15:0] unlock_r;
   logic        save_r;
   logic        fclr_r;
   logic        unlocked;

   assign unlocked = (unlock_r == dcg_pkg::KEY_FLASH);

   // the key is consumed by the next command write
   always_ff @(posedge clock) begin
      if (reset) begin
         unlock_r <= dcg_pkg::RST_UNLOCK;
      end else if (wr_unlock) begin
         unlock_r <= req.wdata;
      end else if (wr_cmd) begin
         unlock_r <= dcg_pkg::RST_UNLOCK;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         save_r <= 1'b0;
         fclr_r <= 1'b0;
      end else begin
         save_r <= wr_cmd && unlocked && req.wdata == dcg_pkg::CMD_SAVE;
         fclr_r <= wr_cmd && unlocked && req.wdata == dcg_pkg::CMD_CLEAR;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   logic [15:0] rd_nxt;
   logic [15:0] rdata_r;

   // read-only offsets have no write decode at all
   always_comb begin
      rd_nxt = '0;
      case (req.addr)
         dcg_pkg::OFF_MODE: begin
            rd_nxt[dcg_pkg::MODE_VIDEO] = video_r;
         end
         dcg_pkg::OFF_FLAGS: begin
            rd_nxt = flags;
         end
         dcg_pkg::OFF_FORMAT: begin
            rd_nxt[dcg_pkg::FMT_HI:dcg_pkg::FMT_LO] = format_r;
         end
         dcg_pkg::OFF_EXPO: begin
            rd_nxt = expo_r;
         end
         dcg_pkg::OFF_HWID: begin
            rd_nxt = HW_ID;
         end
         dcg_pkg::OFF_BOARD: begin
            rd_nxt[3:0] = BOARD_REV;
         end
         dcg_pkg::OFF_FREQ: begin
            rd_nxt = freq_r;
         end
         dcg_pkg::OFF_UNLOCK: begin
            rd_nxt = unlock_r;
         end
         dcg_pkg::OFF_SWVER: begin
            rd_nxt = {VER_MAJOR, VER_MINOR, VER_FIX};
         end
         dcg_pkg::OFF_FRATE: begin
            rd_nxt = frate_r;
         end
         default: begin
            rd_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= req.rd ? rd_nxt : '0;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rdata              = rdata_r;
   assign video_mode         = video_r;
   assign content_select     = format_r;
   assign exposure_us        = expo_r;
   assign mod_freq           = freq_r;
   assign frame_rate         = frate_r;
   assign cmd.manual_frame   = trig_r;
   assign cmd.snapshot       = snap_r;
   assign cmd.flash_save     = save_r;
   assign cmd.flash_clear    = fclr_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_flash_needs_key: assert property (@(posedge clock) disable iff (reset)
      (wr_cmd && unlock_r != dcg_pkg::KEY_FLASH) |=> !save_r && !fclr_r)
      else $error("flash command taken without key");
   a_key_then_save: assert property (@(posedge clock) disable iff (reset)
      (wr_unlock && req.wdata == dcg_pkg::KEY_FLASH) ##1
      (wr_cmd && req.wdata == dcg_pkg::CMD_SAVE) |=> save_r)
      else $error("unlocked save not issued");
   a_mode_select: assert property (@(posedge clock) disable iff (reset)
      wr_mode |=> video_mode == $past(req.wdata[dcg_pkg::MODE_VIDEO]))
      else $error("mode bit not taken");
   a_trig_pulse: assert property (@(posedge clock) disable iff (reset)
      (wr_mode && req.wdata[dcg_pkg::MODE_TRIG]) |=> cmd.manual_frame ##1
      (!cmd.manual_frame || $past(wr_mode && req.wdata[dcg_pkg::MODE_TRIG])))
      else $error("manual frame not one pulse");
   a_clear_flags: assert property (@(posedge clock) disable iff (reset)
      clr_r && !(|(u_flags.raw & dcg_pkg::STICKY_MASK)) |=>
      (u_flags.sticky_r == '0))
      else $error("flag clear failed");
   a_snap_pulse: assert property (@(posedge clock) disable iff (reset)
      (wr_mode && req.wdata[dcg_pkg::MODE_SNAP]) |=> cmd.snapshot)
      else $error("snapshot not issued");
   a_expo_range: assert property (@(posedge clock) disable iff (reset)
      exposure_us >= dcg_pkg::EXPO_MIN && exposure_us <= dcg_pkg::EXPO_MAX)
      else $error("exposure out of range");
   a_format_range: assert property (@(posedge clock) disable iff (reset)
      content_select <= dcg_pkg::FORMAT_MAX)
      else $error("content code out of range");
   a_ro_read_hwid: assert property (@(posedge clock) disable iff (reset)
      (req.rd && req.addr == dcg_pkg::OFF_HWID) |=> rdata == HW_ID)
      else $error("identifier read wrong");
   a_tim_fault_flag: assert property (@(posedge clock) disable iff (reset)
      cond_s.tim_fault |-> flags[dcg_pkg::FL_TIM_ERR])
      else $error("timing fault not shown");
   a_trig_quiet: assert property (@(posedge clock) disable iff (reset)
      !(wr_mode && req.wdata[dcg_pkg::MODE_TRIG]) |=> !cmd.manual_frame)
      else $error("manual frame without request");
   a_snap_quiet: assert property (@(posedge clock) disable iff (reset)
      !(wr_mode && req.wdata[dcg_pkg::MODE_SNAP]) |=> !cmd.snapshot)
      else $error("snapshot without request");
   a_clear_quiet: assert property (@(posedge clock) disable iff (reset)
      !(wr_mode && req.wdata[dcg_pkg::MODE_CLR]) |=> !clr_r)
      else $error("flag clear without request");
   a_clear_set_wins: assert property (@(posedge clock) disable iff (reset)
      clr_r |=> u_flags.sticky_r == $past(u_flags.raw & dcg_pkg::STICKY_MASK))
      else $error("event lost in clear cycle");
   a_sticky_kept: assert property (@(posedge clock) disable iff (reset)
      (flags[dcg_pkg::FL_RESTORE] && !clr_r) |=> flags[dcg_pkg::FL_RESTORE])
      else $error("restore flag lost");
   a_level_follow: assert property (@(posedge clock) disable iff (reset)
      !cond_s.board_temp_err |-> !flags[dcg_pkg::FL_BOARD_T])
      else $error("board temperature flag stuck");
   a_format_keep: assert property (@(posedge clock) disable iff (reset)
      (wr_format && fmt_in > dcg_pkg::FORMAT_MAX) |=> $stable(content_select))
      else $error("illegal content code taken");
   a_expo_clamp: assert property (@(posedge clock) disable iff (reset)
      (wr_expo && req.wdata > dcg_pkg::EXPO_MAX) |=> exposure_us == dcg_pkg::EXPO_MAX)
      else $error("exposure not clamped");
   a_key_consumed: assert property (@(posedge clock) disable iff (reset)
      wr_cmd |=> !unlocked)
      else $error("unlock word not consumed");
   a_freq_taken: assert property (@(posedge clock) disable iff (reset)
      wr_freq |=> mod_freq == $past(req.wdata))
      else $error("frequency write not taken");
endmodule

// >>> dv/tb.sv
// tb: self-checking bench for the camera general register group
`timescale 1ns/1ps
`define CHK(a, b) begin \
   n_tests++; \
   if ((a) !== (b)) begin \
      mismatches++; \
      $display("wrong value at %0t: got %h, expected %h", $time, a, b); \
   end \
end
module tb;
   // ****************************************************************
   // signals and tables
   // ****************************************************************
   localparam logic [15:0] HWID = 16'h1357; // arbitrary value
   localparam logic [3:0]  BREV = 4'h2;     // arbitrary value
   localparam logic [5:0]  VFIX = 6'h2A;    // arbitrary value
   localparam logic [4:0]  VMIN = 5'h13;    // arbitrary value
   localparam logic [4:0]  VMAJ = 5'h0B;    // arbitrary value
   logic               clock      = 1'b0;
   logic               reset      = 1'b1;
   logic               run        = 1'b0;
   logic               rd_q       = 1'b0;
   dcg_pkg::dcg_req_t  req        = '0;
   dcg_pkg::dcg_cond_t cond_async = '0;
   logic        [15:0] rdata;
   logic               video_mode;
   logic        [7:0]  content_select;
   logic        [15:0] exposure_us;
   logic        [15:0] mod_freq;
   logic        [15:0] frame_rate;
   dcg_pkg::dcg_cmd_t  cmd;
   int                 mismatches = 0;
   int                 n_tests    = 0;
   int                 cyc        = 0;
   logic        [15:0] exp_d;
   dcg_pkg::dcg_cmd_t  exp_c;
   logic        [15:0] rq [$];
   dcg_pkg::dcg_cmd_t  cq [$];
   int unsigned        pos [10] = '{3, 4, 5, 6, 8, 10, 11, 13, 14, 15};
   logic        [15:0] ta [12] = '{16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
                                   16'h0009, 16'h8000, 16'hA000, 16'h0022, 16'h0033, 16'h0002};
   logic        [15:0] tv [12] = '{16'h0001, 16'h0040, 16'h0000, 16'h05DC, HWID,
                                   {12'h000, BREV}, 16'h07D0, {VMAJ, VMIN, VFIX},
                                   16'h0028, 16'h0000, 16'h0000, 16'h0000};
   logic        [15:0] ew [6]  = '{16'h0000, 16'h0001, 16'h1D4C, 16'h1D4D, 16'hFFFF, 16'h05DC};
   logic        [15:0] ee [6]  = '{16'h0001, 16'h0001, 16'h1D4C, 16'h1D4C, 16'h1D4C, 16'h05DC};

   dcg_regs #(
      .HW_ID     (HWID),
      .BOARD_REV (BREV),
      .VER_FIX   (VFIX),
      .VER_MINOR (VMIN),
      .VER_MAJOR (VMAJ)
   ) i_dut (
      .clock          (clock),
      .reset          (reset),
      .req            (req),
      .rdata          (rdata),
      .cond_async     (cond_async),
      .video_mode     (video_mode),
      .content_select (content_select),
      .exposure_us    (exposure_us),
      .mod_freq       (mod_freq),
      .frame_rate     (frame_rate),
      .cmd            (cmd)
   );

   always #10 clock = ~clock;

   // ****************************************************************
   // bus tasks, flag model and verdict
   // ****************************************************************
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clock);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      rq.push_back(e);
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clock);
         req <= '0;
      end
   endtask

   function automatic logic [15:0] fmap(input logic [9:0] c);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 10; i++) begin
         if (c[9 - i]) r[pos[i]] = 1'b1;
      end
      return r;
   endfunction

   task automatic conclude();
      if (rq.size() != 0 || cq.size() != 0) mismatches++;
      $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // monitor: read answers and command pulses against the notes
   // ****************************************************************
   always @(posedge clock) begin
      if (run && rd_q) begin
         exp_d = rq.pop_front();
         `CHK(rdata, exp_d)
      end
      if (run && cmd !== 4'h0) begin
         if (cq.size() == 0) `CHK(cmd, 4'h0)
         else begin
            exp_c = cq.pop_front();
            `CHK(cmd, exp_c)
         end
      end
      rd_q <= req.rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end

   // ****************************************************************
   // stimulus
   // ****************************************************************
   initial begin
      logic [15:0] v;
      logic [15:0] sticky;
      logic [7:0]  code;
      logic [7:0]  kept;
      logic [9:0]  c;
      void'($urandom(32662));
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      run <= 1'b1;
      idle(1);
      `CHK(video_mode, 1'b1)
      `CHK(exposure_us, 16'h05DC)
      `CHK(mod_freq, 16'h07D0)
      // reset values, then again after writes to read-only places
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            for (int j = 4; j < 8; j++) begin
               if (j != 6) wr(ta[j], 16'($urandom));
            end
            wr(16'h0003, 16'($urandom));
            wr(16'h0002, 16'($urandom));
         end
         for (int j = 0; j < 12; j++) rd(ta[j], tv[j]);
      end
      // mode bits: trigger, snapshot, back to back
      wr(16'h0001, 16'h0810);
      cq.push_back(4'hC);
      wr(16'h0001, 16'h0010);
      cq.push_back(4'h8);
      rd(16'h0001, 16'h0000);
      idle(2);
      `CHK(video_mode, 1'b0)
      wr(16'h0001, 16'h0041);
      rd(16'h0001, 16'h0001);
      idle(2);
      `CHK(video_mode, 1'b1)
      rd(16'h0003, 16'h0000);
      // each condition alone, then sticky leftovers
      sticky = 16'h0000;
      for (int i = 0; i < 10; i++) begin
         c = 10'h200 >> i;
         cond_async <= c;
         idle(4);
         sticky |= fmap(c) & dcg_pkg::STICKY_MASK;
         rd(16'h0003, sticky | fmap(c));
      end
      cond_async <= '0;
      idle(4);
      rd(16'h0003, 16'h2D40);
      for (int i = 0; i < 3; i++) begin
         c = 10'($urandom);
         cond_async <= c;
         idle(4);
         wr(16'h0001, 16'h0041);
         idle(3);
         rd(16'h0003, fmap(c));
      end
      cond_async <= '0;
      idle(4);
      wr(16'h0001, 16'h0041);
      idle(3);
      rd(16'h0003, 16'h0000);
      // every content code, then codes out of range
      kept = 8'h00;
      for (int k = 0; k < 24; k++) begin
         code = (k == 23) ? 8'hFF : 8'(k);
         if (code <= 8'h15) kept = code;
         wr(16'h0004, {5'h00, code, 3'h0});
         rd(16'h0004, {5'h00, kept, 3'h0});
      end
      idle(2);
      `CHK(content_select, kept)
      // exposure limits and settings
      for (int j = 0; j < 6; j++) begin
         wr(16'h0005, ew[j]);
         rd(16'h0005, ee[j]);
      end
      v = 16'(1 + $urandom % 7500);
      wr(16'h0005, v);
      rd(16'h0005, v);
      rd(16'h0009, 16'h07D0);
      idle(2);
      `CHK(exposure_us, v)
      v = 16'($urandom);
      wr(16'h0009, v);
      wr(16'hA000, ~v);
      rd(16'h0009, v);
      rd(16'hA000, ~v);
      idle(2);
      `CHK(mod_freq, v)
      `CHK(frame_rate, ~v)
      // guarded flash commands
      wr(16'h0033, 16'h0001);
      wr(16'h0022, 16'h4876);
      wr(16'h0033, 16'h0001);
      wr(16'h0022, 16'h4877);
      rd(16'h0022, 16'h4877);
      wr(16'h0033, 16'h0001);
      cq.push_back(4'h2);
      rd(16'h0022, 16'h0000);
      wr(16'h0033, 16'h0002);
      wr(16'h0022, 16'h4877);
      wr(16'h0033, 16'h0002);
      cq.push_back(4'h1);
      rd(16'h0033, 16'h0000);
      idle(4);
      conclude();
   end
endmodule
